// file: rtl/uct_pkg.sv
// Purpose: Shared constants and types for the second serial-port control block
// Assumes: Byte-wide register port, register offsets as printed
// Notes: Offsets other than the control-two one are local choices
package uct_pkg;
    localparam logic [2:0] UCT_OFF_BAUD = 3'h0;
    localparam logic [2:0] UCT_OFF_CTL1 = 3'h2;
    localparam logic [2:0] UCT_OFF_CTL2 = 3'h3;
    localparam logic [2:0] UCT_OFF_STAT = 3'h4;
    localparam logic [2:0] UCT_OFF_DATA = 3'h7;
    localparam logic [7:0] UCT_CTL2_RST = 8'h00;
    localparam logic [7:0] UCT_BAUD_RST = 8'h0F;
    localparam int UCT_B_TXIE = 7;
    localparam int UCT_B_DONEIE = 6;
    localparam int UCT_B_RXIE = 5;
    localparam int UCT_B_IDLEIE = 4;
    localparam int UCT_B_TXON = 3;
    localparam int UCT_B_RXON = 2;
    localparam int UCT_B_STBY = 1;
    localparam int UCT_B_BRK = 0;
    localparam logic [3:0] UCT_BITS_8 = 4'hA;
    localparam logic [3:0] UCT_BITS_9 = 4'hB;
    localparam logic [3:0] UCT_BRK_EXTRA = 4'h3;
    localparam logic [3:0] UCT_DATA_8 = 4'h8;
    localparam logic [3:0] UCT_DATA_9 = 4'h9;

    // Control one: the fields this block uses, plus two spare bits
    typedef struct packed {
        logic single_line_direction;
        logic long_break;
        logic loopback_select;
        logic rx_source;
        logic nine_bit;
        logic wake_method;
        logic [1:0] spare;
    } uct_ctl1_s;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } uct_bus_s;

    typedef enum logic {TXS_IDLE = 1'b0, TXS_BUSY = 1'b1} uct_tx_e;
    typedef enum logic [1:0] {
        RXS_IDLE = 2'b00,
        RXS_START = 2'b01,
        RXS_DATA = 2'b11,
        RXS_STOP = 2'b10
    } uct_rx_e;
    typedef enum logic [1:0] {TXK_DATA = 2'h0, TXK_IDLE = 2'h1, TXK_BREAK = 2'h2} uct_kind_e;
endpackage

// file: rtl/uct_top.sv
// Purpose: Serial port governed by control register two: enables, standby, break
// Assumes: One clock; pins synchronised here; bus port is same-clock logic
// Notes: Status bits share the layout of the enables in control two
// Behaviour
// - Transmit-buffer-empty flag raises interrupt when its enable is set.
// - Transmission-complete flag raises interrupt when its enable is set.
// - Receive-buffer-full flag raises interrupt when its enable is set.
// - Idle-line flag raises interrupt when its enable is set.
// - Control two always readable and writable; all fields reset to zero.
// - Single-wire mode: direction bit decides drive or receive on line.
// - Re-enabling transmitter during transmission queues one idle character.
// - After disable, the character in progress finishes; queued ones are not sent and keep the line driven.
// - Receive line released while receive enable is zero.
// - Loopback releases receive line even when receiver is enabled.
// - Standby waits for idle line or address-mark per wake method.
// - Wakeup condition clears standby bit by hardware.
// - Writing one then zero to break bit queues one break.
// - Break bit held keeps queuing breaks of 10/11 or 13/14 bits.
// - A write of one while the break bit is already set queues no second break; the bit must be cleared first.
// - Loopback with receive source joins transmitter and receiver on one line.
// - Nine-bit mode frames start, eight data, ninth bit, stop.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module uct_top
    import uct_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire uct_bus_s bus,
    output logic [7:0] rdata,
    output logic irq,
    output logic txd_out,
    output logic txd_oe,
    input wire logic txd_in,
    input wire logic rxd_in,
    output logic rx_pin_owned
);
    logic [7:0] ctl2_q, baud_q, txbuf_q, rxdat_q, rdata_q;
    uct_ctl1_s ctl1_q;
    logic txbuf_empty, tx_done_flag, rxbuf_full_q, idle_q, txfull_q;
    uct_rx_e rxs_q;
    logic txd_s1_q, txd_s2_q, rxd_s1_q, rxd_s2_q;
    logic [7:0] tdiv_q, rdiv_q;
    logic [11:0] sh_q;
    logic [3:0] tcnt_q, rcnt_q, icnt_q;
    logic [8:0] rsh_q;
    logic [1:0] kind_q;
    logic brk_req_q, idle_req_q, txon_d1_q, idle_arm_q;
    uct_tx_e txs, txs_q;
    uct_rx_e rxs;
    assign txs = txs_q;
    assign rxs = rxs_q;

    wire tx_on = ctl2_q[UCT_B_TXON];
    wire rx_on = ctl2_q[UCT_B_RXON];
    wire standby = ctl2_q[UCT_B_STBY];
    wire break_send = ctl2_q[UCT_B_BRK];
    wire wr_ctl2 = bus.wr && bus.addr == UCT_OFF_CTL2;
    wire wr_stat = bus.wr && bus.addr == UCT_OFF_STAT;
    wire wr_data = bus.wr && bus.addr == UCT_OFF_DATA;
    wire [3:0] frame_bits = ctl1_q.nine_bit ? UCT_BITS_9 : UCT_BITS_8;
    wire [3:0] data_bits = ctl1_q.nine_bit ? UCT_DATA_9 : UCT_DATA_8;
    wire [3:0] brk_bits = frame_bits + (ctl1_q.long_break ? UCT_BRK_EXTRA : 4'h0);
    wire tick = tdiv_q == 8'h00;
    wire rtick = rdiv_q == 8'h00;
    wire single_wire = ctl1_q.loopback_select && ctl1_q.rx_source;
    wire tx_line = (txs == TXS_BUSY) ? sh_q[0] : 1'b1;
    // Start priority: break, then queued idle, then buffered data
    wire go_brk = tick && txs == TXS_IDLE && tx_on && (brk_req_q || break_send);
    wire go_idle = tick && txs == TXS_IDLE && tx_on && !go_brk && idle_req_q;
    wire go_data = tick && txs == TXS_IDLE && tx_on && !go_brk && !idle_req_q && txfull_q;
    wire tx_end = tick && txs == TXS_BUSY && tcnt_q == 4'h1;
    wire pending = txs == TXS_BUSY || txfull_q || idle_req_q || brk_req_q;
    wire rx_line = !ctl1_q.loopback_select ? rxd_s2_q : (ctl1_q.rx_source ? txd_s2_q : tx_line);
    wire rx_run = rx_on;
    wire rx_msb = ctl1_q.nine_bit ? rsh_q[8] : rsh_q[7];
    wire rx_got = rtick && rxs == RXS_STOP && rx_line;
    wire wake_mark = rx_got && standby && ctl1_q.wake_method && rx_msb;
    wire idle_hit = rtick && rxs == RXS_IDLE && rx_line && idle_arm_q && icnt_q == frame_bits;
    wire wake_idle = idle_hit && standby && !ctl1_q.wake_method;
    wire deliver = rx_got && (!standby || wake_mark);
    wire [7:0] stat = {txbuf_empty, tx_done_flag, rxbuf_full_q, idle_q, 4'h0};

    assign txbuf_empty = !txfull_q;
    assign tx_done_flag = txbuf_empty && txs == TXS_IDLE && !idle_req_q && !brk_req_q;
    assign irq = |(stat[7:4] & ctl2_q[7:4]);
    assign txd_oe = (tx_on || pending) && (!single_wire || ctl1_q.single_line_direction);
    assign txd_out = tx_line;
    assign rx_pin_owned = rx_on && !ctl1_q.loopback_select;
    assign rdata = rdata_q;

    wire [7:0] rd_mux = (bus.addr == UCT_OFF_BAUD) ? baud_q :
                        (bus.addr == UCT_OFF_CTL1) ? ctl1_q :
                        (bus.addr == UCT_OFF_CTL2) ? ctl2_q :
                        (bus.addr == UCT_OFF_STAT) ? stat :
                        (bus.addr == UCT_OFF_DATA) ? rxdat_q : 8'h00;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            txd_s1_q <= 1'b1;
            txd_s2_q <= 1'b1;
            rxd_s1_q <= 1'b1;
            rxd_s2_q <= 1'b1;
            rdata_q <= 8'h00;
            baud_q <= UCT_BAUD_RST;
            ctl1_q <= '0;
        end else begin
            txd_s1_q <= txd_in;
            txd_s2_q <= txd_s1_q;
            rxd_s1_q <= rxd_in;
            rxd_s2_q <= rxd_s1_q;
            rdata_q <= bus.rd ? rd_mux : 8'h00;
            if (bus.wr && bus.addr == UCT_OFF_BAUD) begin
                baud_q <= bus.wdata;
            end
            if (bus.wr && bus.addr == UCT_OFF_CTL1) begin
                ctl1_q <= bus.wdata;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctl2_q <= UCT_CTL2_RST;
            txon_d1_q <= 1'b0;
        end else begin
            txon_d1_q <= tx_on;
            if (wr_ctl2) begin
                ctl2_q <= bus.wdata;
            end else if (wake_mark || wake_idle) begin
                ctl2_q[UCT_B_STBY] <= 1'b0;
            end
        end
    end

    // Requests: a new request wins over the clear of the consumed one
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            brk_req_q <= 1'b0;
            idle_req_q <= 1'b0;
        end else begin
            if (wr_ctl2 && bus.wdata[UCT_B_BRK] && !break_send) begin
                brk_req_q <= 1'b1;
            end else if (go_brk) begin
                brk_req_q <= 1'b0;
            end
            if (tx_on && !txon_d1_q) begin
                idle_req_q <= 1'b1;
            end else if (go_idle) begin
                idle_req_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            txfull_q <= 1'b0;
            txbuf_q <= 8'h00;
        end else begin
            if (wr_data) begin
                txfull_q <= 1'b1;
                txbuf_q <= bus.wdata;
            end else if (go_data) begin
                txfull_q <= 1'b0;
            end
        end
    end

    // Transmitter; bit clock is a divider enable pulse
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tdiv_q <= 8'h00;
            txs_q <= TXS_IDLE;
            sh_q <= '1;
            tcnt_q <= 4'h0;
            kind_q <= TXK_DATA;
        end else begin
            tdiv_q <= tick ? baud_q : tdiv_q - 8'h01;
            case (txs)
                TXS_IDLE: begin
                    if (go_brk) begin
                        txs_q <= TXS_BUSY;
                        sh_q <= '0;
                        tcnt_q <= brk_bits;
                        kind_q <= TXK_BREAK;
                    end else if (go_idle) begin
                        txs_q <= TXS_BUSY;
                        sh_q <= '1;
                        tcnt_q <= frame_bits;
                        kind_q <= TXK_IDLE;
                    end else if (go_data) begin
                        txs_q <= TXS_BUSY;
                        sh_q <= {2'b11, ctl1_q.nine_bit ? 1'b0 : 1'b1, txbuf_q, 1'b0};
                        tcnt_q <= frame_bits;
                        kind_q <= TXK_DATA;
                    end
                end
                TXS_BUSY: begin
                    if (tick) begin
                        sh_q <= {kind_q != TXK_BREAK, sh_q[11:1]};
                        tcnt_q <= tcnt_q - 4'h1;
                        if (tx_end) begin
                            txs_q <= TXS_IDLE;
                            sh_q <= '1;
                        end
                    end
                end
                default: txs_q <= TXS_IDLE;
            endcase
        end
    end

    // Receiver with idle detection and standby wakeup
    // Standby wakeup
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rxs_q <= RXS_IDLE;
            rdiv_q <= 8'h00;
            rcnt_q <= 4'h0;
            icnt_q <= 4'h0;
            rsh_q <= 9'h000;
            idle_arm_q <= 1'b0;
        end else if (!rx_run) begin
            rxs_q <= RXS_IDLE;
            rdiv_q <= baud_q;
            icnt_q <= 4'h0;
            idle_arm_q <= 1'b0;
        end else begin
            rdiv_q <= rtick ? baud_q : rdiv_q - 8'h01;
            case (rxs)
                RXS_IDLE: begin
                    if (!rx_line) begin
                        rxs_q <= RXS_START;
                        rdiv_q <= {1'b0, baud_q[7:1]};
                        icnt_q <= 4'h0;
                    end else if (rtick) begin
                        icnt_q <= idle_hit ? 4'h0 : icnt_q + 4'h1;
                        if (idle_hit) begin
                            idle_arm_q <= 1'b0;
                        end
                    end
                end
                RXS_START: begin
                    if (rtick) begin
                        rxs_q <= rx_line ? RXS_IDLE : RXS_DATA;
                        rcnt_q <= data_bits;
                    end
                end
                RXS_DATA: begin
                    if (rtick) begin
                        rsh_q <= ctl1_q.nine_bit ? {rx_line, rsh_q[8:1]}
                                                 : {1'b0, rx_line, rsh_q[7:1]};
                        rcnt_q <= rcnt_q - 4'h1;
                        if (rcnt_q == 4'h1) begin
                            rxs_q <= RXS_STOP;
                        end
                    end
                end
                RXS_STOP: begin
                    if (rtick) begin
                        rxs_q <= RXS_IDLE;
                        idle_arm_q <= 1'b1;
                    end
                end
                default: rxs_q <= RXS_IDLE;
            endcase
        end
    end

    // Sticky receive flags; hardware set wins over a write-one clear
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rxbuf_full_q <= 1'b0;
            idle_q <= 1'b0;
            rxdat_q <= 8'h00;
        end else begin
            if (deliver) begin
                rxbuf_full_q <= 1'b1;
                rxdat_q <= rsh_q[7:0];
            end else if (wr_stat && bus.wdata[UCT_B_RXIE]) begin
                rxbuf_full_q <= 1'b0;
            end
            if (idle_hit && !standby) begin
                idle_q <= 1'b1;
            end else if (wr_stat && bus.wdata[UCT_B_IDLEIE]) begin
                idle_q <= 1'b0;
            end
        end
    end

    sequence s_brk_start;
        txs == TXS_BUSY && kind_q == TXK_BREAK && sh_q[0] == 1'b0;
    endsequence
    sequence s_two_writes;
        wr_ctl2 ##1 !wr_ctl2;
    endsequence

    property p_irq_txbuf;
        @(posedge sys_clk) disable iff (!nrst)
        ctl2_q[UCT_B_TXIE] && txbuf_empty |-> irq;
    endproperty
    a_irq_txbuf: assert property (p_irq_txbuf) else $error("txbuf irq missing");
    property p_irq_done;
        @(posedge sys_clk) disable iff (!nrst)
        !irq |-> !(ctl2_q[UCT_B_DONEIE] && tx_done_flag);
    endproperty
    a_irq_done: assert property (p_irq_done) else $error("done irq missing");
    property p_irq_rx;
        @(posedge sys_clk) disable iff (!nrst)
        deliver && ctl2_q[UCT_B_RXIE] && !wr_ctl2 |=> irq;
    endproperty
    a_irq_rx: assert property (p_irq_rx) else $error("rx irq missing");
    property p_irq_none;
        @(posedge sys_clk) disable iff (!nrst)
        ctl2_q[7:4] == 4'h0 |-> !irq;
    endproperty
    a_irq_none: assert property (p_irq_none) else $error("irq without enable");
    property p_ctl2_rw;
        @(posedge sys_clk) disable iff (!nrst)
        s_two_writes ##0 (bus.rd && bus.addr == UCT_OFF_CTL2) |=> rdata == $past(bus.wdata, 2);
    endproperty
    a_ctl2_rw: assert property (p_ctl2_rw) else $error("control two readback wrong");
    property p_hold_line;
        @(posedge sys_clk) disable iff (!nrst)
        txs == TXS_BUSY && !single_wire |-> txd_oe;
    endproperty
    a_hold_line: assert property (p_hold_line) else $error("line dropped mid char");
    property p_rx_pin;
        @(posedge sys_clk) disable iff (!nrst)
        ctl1_q.loopback_select || !rx_on |-> !rx_pin_owned;
    endproperty
    a_rx_pin: assert property (p_rx_pin) else $error("rx pin held");
    property p_break;
        @(posedge sys_clk) disable iff (!nrst)
        go_brk |=> s_brk_start;
    endproperty
    a_break: assert property (p_break) else $error("break not started");
    property p_wake;
        @(posedge sys_clk) disable iff (!nrst)
        (wake_mark || wake_idle) && !wr_ctl2 |=> !standby;
    endproperty
    a_wake: assert property (p_wake) else $error("standby not cleared");
    property p_idle_q;
        @(posedge sys_clk) disable iff (!nrst)
        tx_on && !$past(tx_on) |=> idle_req_q;
    endproperty
    a_idle_q: assert property (p_idle_q) else $error("idle not queued");
endmodule
`default_nettype wire

// file: verif/uct_node.sv
// Purpose: Remote serial node on the far side of the port, 8-bit frames
// Assumes: Bit period of BIT_CYC system clocks, line idle high
// Notes: Low runs on the line are measured so break characters can be timed
`timescale 1ns/100ps
`default_nettype none
module uct_node #(
    parameter int BIT_CYC = 16
) (
    input wire logic sys_clk,
    input wire logic line_in,
    output logic line_out
);
    logic [7:0] rx_byte = 8'h00;
    int rx_cnt = 0;
    int run_cnt = 0;
    int low_q = 0;
    int last_low = 0;

    initial line_out = 1'b1;

    // Start bit, eight data bits lsb first, stop bit
    task automatic send(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge sys_clk);
            line_out <= f[i];
            repeat (BIT_CYC - 1) @(posedge sys_clk);
        end
    endtask

    // Length of each low run, in clocks, kept when the line rises
    always @(posedge sys_clk) begin
        if (line_in) begin
            if (low_q != 0) begin
                last_low <= low_q;
                run_cnt <= run_cnt + 1;
            end
            low_q <= 0;
        end else begin
            low_q <= low_q + 1;
        end
    end

    // Mid-bit sampling; a frame with a low stop bit is not delivered
    initial begin : rx_loop
        logic [7:0] sh;
        forever begin
            @(negedge line_in);
            repeat (BIT_CYC / 2) @(posedge sys_clk);
            if (!line_in) begin
                for (int i = 0; i < 8; i++) begin
                    repeat (BIT_CYC) @(posedge sys_clk);
                    sh[i] = line_in;
                end
                repeat (BIT_CYC) @(posedge sys_clk);
                if (line_in) begin
                    rx_byte = sh;
                    rx_cnt++;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: verif/testbench.sv
// Purpose: Self-checking bench for control register two and the serial traffic it governs
// Assumes: Reset baud divisor, so one bit lasts sixteen clocks
// Notes: Transmit line has a pull-up while the port does not drive it
`timescale 1ns/100ps
`default_nettype none
module testbench
    import uct_pkg::*;
;
    localparam int BIT = int'(UCT_BAUD_RST) + 1;
    logic sys_clk;
    logic nrst;
    uct_bus_s bus;
    logic [7:0] rdata;
    logic irq;
    logic txd_out;
    logic txd_oe;
    logic node_tx;
    logic rx_pin_owned;
    wire logic line;
    int err_count = 0;
    int checks_done = 0;
    logic [7:0] v;

    assign line = txd_oe ? txd_out : 1'b1;

    uct_top dut_u (.sys_clk(sys_clk), .nrst(nrst), .bus(bus), .rdata(rdata), .irq(irq),
        .txd_out(txd_out), .txd_oe(txd_oe), .txd_in(line), .rxd_in(node_tx),
        .rx_pin_owned(rx_pin_owned));
    uct_node #(.BIT_CYC(BIT)) node_u (.sys_clk(sys_clk), .line_in(line), .line_out(node_tx));

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus.wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    // Write then read the same offset on the very next cycle
    task automatic wr_rd(input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        #1;
        q = rdata;
    endtask

    task automatic rchk(input string what, input logic [2:0] a, input logic [7:0] m,
        input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(what, {8'h00, d & m}, {8'h00, e});
    endtask

    // Bounded wait: 0 byte received, 1 low run ended, 2 line released, 3 irq, 4 line low
    task automatic wait_for(input int k, input int old);
        for (int n = 0; n < 5000; n++) begin
            @(posedge sys_clk);
            #1;
            if (k == 0 && node_u.rx_cnt != old) return;
            if (k == 1 && node_u.run_cnt != old) return;
            if (k == 2 && txd_oe === 1'b0) return;
            if (k == 3 && irq === 1'b1) return;
            if (k == 4 && txd_out === 1'b0) return;
        end
        err_count++;
        $display("unexpected timeout waiting on event %0d", k);
        conclude();
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial begin
        #900000;
        err_count++;
        $display("unexpected timeout of the whole run");
        conclude();
    end

    initial begin
        int old;
        nrst = 1'b0;
        bus = '0;
        repeat (20) @(posedge sys_clk);
        nrst <= 1'b1;
        rchk("control two reset", UCT_OFF_CTL2, 8'hFF, UCT_CTL2_RST);
        @(posedge sys_clk);
        #1;
        chk("rdata idle", {8'h00, rdata}, 16'h0000);
        rchk("status reset", UCT_OFF_STAT, 8'hF0, 8'hC0);
        wr_rd(UCT_OFF_CTL2, 8'hF0, v);
        chk("control two", {8'h00, v}, 16'h00F0);
        wr(3'h1, 8'hFF);
        rchk("unmapped", 3'h1, 8'hFF, 8'h00);
        rchk("control two kept", UCT_OFF_CTL2, 8'hFF, 8'hF0);
        for (int i = UCT_B_IDLEIE; i <= UCT_B_TXIE; i++) begin
            wr(UCT_OFF_CTL2, 8'h01 << i);
            chk("irq per enable", {15'h0, irq}, 16'(i >= UCT_B_DONEIE));
        end
        wr(UCT_OFF_CTL2, 8'h00);
        chk("irq masked", {15'h0, irq}, 16'h0);
        $display("test registers and interrupts done");

        wr(UCT_OFF_CTL2, 8'h08);
        chk("txd_oe on", {15'h0, txd_oe}, 16'h1);
        old = node_u.rx_cnt;
        wr(UCT_OFF_DATA, 8'h5A);
        wait_for(0, old);
        chk("byte sent", {8'h00, node_u.rx_byte}, 16'h005A);
        old = node_u.rx_cnt;
        wr(UCT_OFF_DATA, 8'hC3);
        wait_for(4, 0);
        wr(UCT_OFF_CTL2, 8'h00);
        chk("txd_oe held", {15'h0, txd_oe}, 16'h1);
        wait_for(0, old);
        chk("byte after disable", {8'h00, node_u.rx_byte}, 16'h00C3);
        wait_for(2, 0);
        chk("line idle", {15'h0, txd_out}, 16'h1);
        $display("test transmit done");

        wr(UCT_OFF_CTL2, 8'h08);
        for (int k = 0; k < 2; k++) begin
            wr(UCT_OFF_CTL1, (k == 1) ? 8'h40 : 8'h00);
            old = node_u.run_cnt;
            wr(UCT_OFF_CTL2, 8'h09);
            wr(UCT_OFF_CTL2, 8'h08);
            wait_for(1, old);
            chk("break length", node_u.last_low[15:0], 16'((10 + 3 * k) * BIT));
        end
        old = node_u.run_cnt;
        wr(UCT_OFF_CTL2, 8'h09);
        wait_for(1, old);
        wait_for(1, old + 1);
        wr(UCT_OFF_CTL2, 8'h08);
        chk("held break length", node_u.last_low[15:0], 16'(13 * BIT));
        repeat (16 * BIT) @(posedge sys_clk);
        chk("breaks while held", node_u.run_cnt[15:0], 16'(old + 2));
        wr(UCT_OFF_CTL1, 8'h30);
        chk("single wire receive", {15'h0, txd_oe}, 16'h0);
        wr(UCT_OFF_CTL1, 8'hB0);
        chk("single wire drive", {15'h0, txd_oe}, 16'h1);
        wr(UCT_OFF_CTL2, 8'h00);
        wr(UCT_OFF_CTL1, 8'h00);
        $display("test break and single wire done");

        chk("rx pin free", {15'h0, rx_pin_owned}, 16'h0);
        wr(UCT_OFF_CTL2, 8'h04);
        chk("rx pin owned", {15'h0, rx_pin_owned}, 16'h1);
        wr(UCT_OFF_CTL1, 8'h20);
        chk("rx pin loopback", {15'h0, rx_pin_owned}, 16'h0);
        wr(UCT_OFF_CTL1, 8'h00);
        wr(UCT_OFF_CTL2, 8'h24);
        node_u.send(8'h3C);
        wait_for(3, 0);
        rchk("rx data", UCT_OFF_DATA, 8'hFF, 8'h3C);
        rchk("rx full", UCT_OFF_STAT, 8'h20, 8'h20);
        repeat (12 * BIT) @(posedge sys_clk);
        wr(UCT_OFF_CTL2, 8'h14);
        chk("irq idle", {15'h0, irq}, 16'h1);
        wr(UCT_OFF_STAT, 8'h30);
        rchk("flags cleared", UCT_OFF_STAT, 8'h30, 8'h00);
        chk("irq cleared", {15'h0, irq}, 16'h0);
        $display("test receive done");

        wr(UCT_OFF_CTL1, 8'h04);
        wr(UCT_OFF_CTL2, 8'h06);
        node_u.send(8'h11);
        repeat (2 * BIT) @(posedge sys_clk);
        rchk("standby held", UCT_OFF_CTL2, 8'hFF, 8'h06);
        rchk("byte dropped", UCT_OFF_STAT, 8'h20, 8'h00);
        node_u.send(8'h91);
        repeat (2 * BIT) @(posedge sys_clk);
        rchk("standby cleared", UCT_OFF_CTL2, 8'hFF, 8'h04);
        rchk("wake byte", UCT_OFF_DATA, 8'hFF, 8'h91);
        $display("test standby done");

        wr(UCT_OFF_CTL1, 8'h00);
        wr(UCT_OFF_CTL2, 8'h06);
        node_u.send(8'h22);
        repeat (2 * BIT) @(posedge sys_clk);
        rchk("standby until idle", UCT_OFF_CTL2, 8'hFF, 8'h06);
        repeat (12 * BIT) @(posedge sys_clk);
        rchk("standby idle wake", UCT_OFF_CTL2, 8'hFF, 8'h04);
        wr(UCT_OFF_STAT, 8'h30);
        wr(UCT_OFF_CTL1, 8'h28);
        wr(UCT_OFF_CTL2, 8'h2C);
        wr(UCT_OFF_DATA, 8'hA5);
        wait_for(3, 0);
        rchk("nine bit loopback", UCT_OFF_DATA, 8'hFF, 8'hA5);
        $display("test idle wake and nine bit done");
        conclude();
    end
endmodule
`default_nettype wire
